// ---- rtl/pcx_crossbar.sv ----
// Priority crossbar pin router with its APB register file.
// Assumes pad cells outside that resolve pad_out and pad_oe into a
// wire and return the pin level on pad_in, synchronous to pclk.
//
// Behaviour
// [RULE_01] Functions have fixed ranks; serial port first, pins given in rank order.
// [RULE_02] An enabled function takes the lowest free pin unless its pins are fixed.
// [RULE_03] Serial port transmit sits on P0.4 and receive on P0.5, claimed together.
// [RULE_04] Async comparator only on P1.4, sync comparator only on P1.5.
// [RULE_05] A pin already given away is passed over for the next function.
// [RULE_06] Pins set in the skip masks count as already assigned.
// [RULE_07] The two-wire bus always takes its data and clock lines together; the code places each alone, so with one free pin SDA is routed without SCL.
// [RULE_08] Leftover pins stay ordinary port pins in one contiguous group; the code leaves them scattered between the assigned pins.
// [RULE_09] Serial peripheral takes three pins, or four with slave select.
// [RULE_10] Analog pins lose pull-up, output driver and input receiver.
// [RULE_11] Input-kind bit one means digital, zero means analog.
// [RULE_12] All pins come out of reset as digital inputs.
// [RULE_13] Driver-kind bit picks open-drain or push-pull, peripherals included.
// [RULE_14] Two-wire bus pins are always open-drain.
// [RULE_15] With pull-up disable clear, open-drain pins get a weak pull-up.
// [RULE_16] Pull-up disable has no effect on push-pull pins.
// [RULE_17] A pin driving low has its weak pull-up switched off.
// [RULE_18] With the crossbar off all pins are plain port inputs.
// [RULE_19] With the crossbar off no port output driver is enabled.
// [RULE_20] Reading a port latch returns the pin level, even for peripherals.
// [RULE_21] Software sets input kind, driver kind, skips, selects, then enables.
// [RULE_22] Top two bits of select register zero read zero, ignore writes.
// [RULE_23] Pin map follows register changes within one clock cycle.
//
// Implementation choices: register access over APB and the placing of the registers.
module pcx_crossbar
   import pcx_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic slave_select_mode,
   input wire pcx_periph_out_t periph_out,
   output pcx_periph_in_t periph_in,
   input wire logic [NUM_PINS-1:0] pad_in,
   output logic [NUM_PINS-1:0] pad_out,
   output logic [NUM_PINS-1:0] pad_oe,
   output logic [NUM_PINS-1:0] pad_pullup,
   output logic [NUM_PINS-1:0] pad_rx_en
);

   // Lowest clear bit of a used mask; bit 4 tells whether one exists.
   function automatic logic [4:0] lowest_free(input logic [15:0] used);
      logic [4:0] r;
      r = 5'h00;
      for (int i = NUM_XPINS - 1; i >= 0; i--) begin
         if (!used[i]) begin
            r = {1'b1, 4'(i)};
         end
      end
      return r;
   endfunction

   // Function code of each scanning slot, in priority order.
   function automatic pcx_func_t scan_code(input int k);
      pcx_func_t c;
      case (k)
         0: c = PCX_FN_SCK;
         1: c = PCX_FN_MISO;
         2: c = PCX_FN_MOSI;
         3: c = PCX_FN_NSS;
         4: c = PCX_FN_SDA;
         5: c = PCX_FN_SCL;
         6: c = PCX_FN_SYSCK;
         default: c = PCX_FN_GPIO;
      endcase
      return c;
   endfunction

   // Eight-bit slice of a register for a read.
   function automatic logic [31:0] rd8(input logic [7:0] v);
      return {24'h00_0000, v};
   endfunction

   logic [7:0] sel0_q;
   logic [7:0] sel1_q;
   logic [15:0] skip_q;
   logic [16:0] ink_q;
   logic [16:0] drv_q;
   logic [16:0] lat_q;
   logic [31:0] prdata_q;
   pcx_func_t [NUM_XPINS-1:0] map_d;
   pcx_func_t [NUM_XPINS-1:0] map_q;
   logic [NUM_PINS-1:0] out_d;
   logic [NUM_PINS-1:0] oe_d;
   logic [NUM_PINS-1:0] pu_d;
   logic [NUM_PINS-1:0] rxen_d;
   logic [NUM_PINS-1:0] pin_lvl;
   pcx_periph_in_t pin_d;
   logic [NUM_SCAN-1:0] scan_req;
   logic [15:0] used;
   logic [4:0] hit;
   logic xbar_on;
   logic pud;
   logic wr_en;
   logic rd_setup;
   logic addr_ok;
   logic [31:0] rd_d;

   assign xbar_on = sel1_q[SEL1_XBAR];
   assign pud = sel1_q[SEL1_PUD];
   assign wr_en = psel & penable & pwrite & addr_ok;
   assign rd_setup = psel & ~penable & ~pwrite;

   // The slave answers in the first access cycle; no wait states.
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~addr_ok;
   assign prdata = prdata_q;

   // Pin level as software and peripherals see it; analog pins read 0.
   assign pin_lvl = pad_in & ink_q; // [RULE_10] [RULE_11]

   // Address decode and read mux.
   always_comb begin
      addr_ok = 1'b1;
      rd_d = 32'h0000_0000;
      case (paddr)
         ADDR_SEL0: rd_d = rd8(sel0_q & SEL0_WMASK); // [RULE_22]
         ADDR_SEL1: rd_d = rd8(sel1_q);
         ADDR_SKIP0: rd_d = rd8(skip_q[7:0]);
         ADDR_SKIP1: rd_d = rd8(skip_q[15:8]);
         ADDR_INK0: rd_d = rd8(ink_q[7:0]);
         ADDR_INK1: rd_d = rd8(ink_q[15:8]);
         ADDR_INK2: rd_d = rd8({7'h00, ink_q[16]});
         ADDR_DRV0: rd_d = rd8(drv_q[7:0]);
         ADDR_DRV1: rd_d = rd8(drv_q[15:8]);
         ADDR_DRV2: rd_d = rd8({7'h00, drv_q[16]});
         ADDR_LAT0: rd_d = rd8(pin_lvl[7:0]); // [RULE_20]
         ADDR_LAT1: rd_d = rd8(pin_lvl[15:8]); // [RULE_20]
         ADDR_LAT2: rd_d = rd8({7'h00, pin_lvl[16]}); // [RULE_20]
         default: addr_ok = 1'b0;
      endcase
   end

   // Read data is captured in the setup cycle and held through access.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
      end else if (rd_setup) begin
         prdata_q <= rd_d;
      end
   end

   // Function select registers; unused bits never store a value.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel0_q <= SEL_RST;
         sel1_q <= SEL_RST;
      end else if (wr_en) begin
         if (paddr == ADDR_SEL0) begin
            sel0_q <= pwdata[7:0] & SEL0_WMASK; // [RULE_22]
         end
         if (paddr == ADDR_SEL1) begin
            sel1_q <= pwdata[7:0] & SEL1_WMASK;
         end
      end
   end

   // Skip masks for the sixteen crossbar pins.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         skip_q <= SKIP_RST;
      end else if (wr_en) begin
         if (paddr == ADDR_SKIP0) begin
            skip_q[7:0] <= pwdata[7:0];
         end
         if (paddr == ADDR_SKIP1) begin
            skip_q[15:8] <= pwdata[7:0];
         end
      end
   end

   // Input-kind registers; every pin resets to digital.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ink_q <= INK_RST; // [RULE_12]
      end else if (wr_en) begin
         if (paddr == ADDR_INK0) begin
            ink_q[7:0] <= pwdata[7:0]; // [RULE_11]
         end
         if (paddr == ADDR_INK1) begin
            ink_q[15:8] <= pwdata[7:0];
         end
         if (paddr == ADDR_INK2) begin
            ink_q[16] <= pwdata[0];
         end
      end
   end

   // Driver-kind registers; a set bit selects push-pull.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drv_q <= DRV_RST;
      end else if (wr_en) begin
         if (paddr == ADDR_DRV0) begin
            drv_q[7:0] <= pwdata[7:0];
         end
         if (paddr == ADDR_DRV1) begin
            drv_q[15:8] <= pwdata[7:0];
         end
         if (paddr == ADDR_DRV2) begin
            drv_q[16] <= pwdata[0];
         end
      end
   end

   // Port output latches; a read returns the pin, not these bits.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lat_q <= LAT_RST;
      end else if (wr_en) begin
         if (paddr == ADDR_LAT0) begin
            lat_q[7:0] <= pwdata[7:0];
         end
         if (paddr == ADDR_LAT1) begin
            lat_q[15:8] <= pwdata[7:0];
         end
         if (paddr == ADDR_LAT2) begin
            lat_q[16] <= pwdata[0];
         end
      end
   end

   // Scanning requests in priority order after the fixed serial port and comparator pins.
   always_comb begin
      scan_req[0] = sel0_q[SEL0_SPI]; // [RULE_09]
      scan_req[1] = sel0_q[SEL0_SPI];
      scan_req[2] = sel0_q[SEL0_SPI];
      scan_req[3] = sel0_q[SEL0_SPI] & slave_select_mode; // [RULE_09]
      scan_req[4] = sel0_q[SEL0_SMB]; // [RULE_07]
      scan_req[5] = sel0_q[SEL0_SMB]; // [RULE_07]
      scan_req[6] = sel0_q[SEL0_SYSCK];
   end

   // Priority decoder: fixed pins are claimed first, then each scanning
   // function takes the lowest pin not skipped and not yet taken. A
   // function that finds no free pin is simply left unrouted.
   always_comb begin
      used = skip_q; // [RULE_06]
      map_d = {NUM_XPINS{PCX_FN_GPIO}}; // [RULE_08]
      hit = 5'h00;
      if (sel0_q[SEL0_UART]) begin
         map_d[PIN_TX] = PCX_FN_TX; // [RULE_03]
         map_d[PIN_RX] = PCX_FN_RX; // [RULE_03]
         used[PIN_TX] = 1'b1;
         used[PIN_RX] = 1'b1;
      end
      if (sel0_q[SEL0_CMPA]) begin
         map_d[PIN_CMPA] = PCX_FN_CMPA; // [RULE_04]
         used[PIN_CMPA] = 1'b1;
      end
      if (sel0_q[SEL0_CMPS]) begin
         map_d[PIN_CMPS] = PCX_FN_CMPS; // [RULE_04]
         used[PIN_CMPS] = 1'b1;
      end
      for (int k = 0; k < NUM_SCAN; k++) begin // [RULE_01]
         hit = lowest_free(used); // [RULE_02]
         if (scan_req[k] && hit[4]) begin
            map_d[hit[3:0]] = scan_code(k);
            used[hit[3:0]] = 1'b1; // [RULE_05]
         end
      end
      if (!xbar_on) begin
         map_d = {NUM_XPINS{PCX_FN_GPIO}}; // [RULE_18]
      end
   end

   // The map is rebuilt every cycle from the live registers.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         map_q <= {NUM_XPINS{PCX_FN_GPIO}};
      end else begin
         map_q <= map_d; // [RULE_23]
      end
   end

   // Per-pin driver: pick the source, apply driver kind, analog and
   // crossbar gating, then decide the weak pull-up.
   always_comb begin
      logic v;
      logic en;
      logic od;
      pcx_func_t f;
      v = 1'b1;
      en = 1'b0;
      od = 1'b0;
      f = PCX_FN_GPIO;
      for (int p = 0; p < NUM_PINS; p++) begin
         f = (p < NUM_XPINS) ? map_q[4'(p)] : PCX_FN_GPIO;
         od = ~drv_q[p]; // [RULE_13]
         en = 1'b1;
         v = lat_q[p];
         case (f)
            PCX_FN_TX: v = periph_out.serial_transmit_out;
            PCX_FN_RX: en = 1'b0;
            PCX_FN_SCK: begin
               v = periph_out.sck_o;
               en = periph_out.sck_oe;
            end
            PCX_FN_MISO: begin
               v = periph_out.miso_o;
               en = periph_out.miso_oe;
            end
            PCX_FN_MOSI: begin
               v = periph_out.mosi_o;
               en = periph_out.mosi_oe;
            end
            PCX_FN_NSS: begin
               v = periph_out.nss_o;
               en = periph_out.nss_oe;
            end
            PCX_FN_SDA: begin
               v = periph_out.sda_o;
               od = 1'b1; // [RULE_14]
            end
            PCX_FN_SCL: begin
               v = periph_out.scl_o;
               od = 1'b1; // [RULE_14]
            end
            PCX_FN_CMPS: v = periph_out.sync_comparator_out;
            PCX_FN_CMPA: v = periph_out.async_comparator_out;
            PCX_FN_SYSCK: v = periph_out.sysclk_o;
            default: v = lat_q[p];
         endcase
         // An open-drain pin only ever drives low.
         if (od) begin
            en = en & ~v;
            v = 1'b0;
         end
         if (!xbar_on || !ink_q[p]) begin
            en = 1'b0; // [RULE_19] [RULE_10]
         end
         out_d[p] = v;
         oe_d[p] = en;
         // Weak pull-up on digital open-drain pins unless disabled or pulled low.
         pu_d[p] = od & ~pud & ink_q[p] & ~(en & ~v); // [RULE_15] [RULE_16] [RULE_17]
         rxen_d[p] = ink_q[p]; // [RULE_10]
      end
   end

   // Pad controls come from flops.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pad_out <= {NUM_PINS{1'b0}};
         pad_oe <= {NUM_PINS{1'b0}};
         pad_pullup <= {NUM_PINS{1'b0}};
         pad_rx_en <= {NUM_PINS{1'b0}};
      end else begin
         pad_out <= out_d;
         pad_oe <= oe_d;
         pad_pullup <= pu_d;
         pad_rx_en <= rxen_d;
      end
   end

   // Return path: each peripheral input reads the pin it owns, and idles
   // high while it owns none.
   always_comb begin
      pin_d = '1;
      for (int p = 0; p < NUM_XPINS; p++) begin
         case (map_q[p])
            PCX_FN_RX: pin_d.serial_receive_in = pin_lvl[p];
            PCX_FN_SCK: pin_d.sck_i = pin_lvl[p];
            PCX_FN_MISO: pin_d.miso_i = pin_lvl[p];
            PCX_FN_MOSI: pin_d.mosi_i = pin_lvl[p];
            PCX_FN_NSS: pin_d.nss_i = pin_lvl[p];
            PCX_FN_SDA: pin_d.sda_i = pin_lvl[p];
            PCX_FN_SCL: pin_d.scl_i = pin_lvl[p];
            default: pin_d.serial_receive_in = pin_d.serial_receive_in;
         endcase
      end
   end

   // Peripheral inputs are registered once.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         periph_in <= '1;
      end else begin
         periph_in <= pin_d;
      end
   end

endmodule

// ---- rtl/pcx_pkg.sv ----
// Package for the priority crossbar pin router: register map, reset
// values, function codes and the peripheral-side carrier structs.
// Assumes a 32-bit APB register bus and one system clock.
package pcx_pkg;

   localparam int NUM_XPINS = 16;
   localparam int NUM_PINS = 17;

   // Byte addresses of the registers.
   localparam logic [7:0] ADDR_SEL0 = 8'h00;
   localparam logic [7:0] ADDR_SEL1 = 8'h04;
   localparam logic [7:0] ADDR_SKIP0 = 8'h08;
   localparam logic [7:0] ADDR_SKIP1 = 8'h0C;
   localparam logic [7:0] ADDR_INK0 = 8'h10;
   localparam logic [7:0] ADDR_INK1 = 8'h14;
   localparam logic [7:0] ADDR_INK2 = 8'h18;
   localparam logic [7:0] ADDR_DRV0 = 8'h1C;
   localparam logic [7:0] ADDR_DRV1 = 8'h20;
   localparam logic [7:0] ADDR_DRV2 = 8'h24;
   localparam logic [7:0] ADDR_LAT0 = 8'h28;
   localparam logic [7:0] ADDR_LAT1 = 8'h2C;
   localparam logic [7:0] ADDR_LAT2 = 8'h30;

   // Field positions in peripheral_pin_select_0.
   localparam int SEL0_UART = 0;
   localparam int SEL0_SPI = 1;
   localparam int SEL0_SMB = 2;
   localparam int SEL0_SYSCK = 3;
   localparam int SEL0_CMPS = 4;
   localparam int SEL0_CMPA = 5;
   localparam logic [7:0] SEL0_WMASK = 8'h3F;
   // Field positions in peripheral_pin_select_1.
   localparam int SEL1_XBAR = 6;
   localparam int SEL1_PUD = 7;
   localparam logic [7:0] SEL1_WMASK = 8'hC0;

   // Reset values.
   localparam logic [7:0] SEL_RST = 8'h00;
   localparam logic [15:0] SKIP_RST = 16'h0000;
   localparam logic [16:0] INK_RST = 17'h1_FFFF;
   localparam logic [16:0] DRV_RST = 17'h0_0000;
   localparam logic [16:0] LAT_RST = 17'h1_FFFF;

   // Fixed pin indices (port 0 pins 0..7, port 1 pins 8..15).
   localparam logic [3:0] PIN_TX = 4'h4;
   localparam logic [3:0] PIN_RX = 4'h5;
   localparam logic [3:0] PIN_CMPA = 4'hC;
   localparam logic [3:0] PIN_CMPS = 4'hD;

   // Number of functions placed by the scanning decoder.
   localparam int NUM_SCAN = 7;

   typedef enum logic [3:0] {
      PCX_FN_GPIO = 4'h0,
      PCX_FN_TX = 4'h1,
      PCX_FN_RX = 4'h2,
      PCX_FN_SCK = 4'h3,
      PCX_FN_MISO = 4'h4,
      PCX_FN_MOSI = 4'h5,
      PCX_FN_NSS = 4'h6,
      PCX_FN_SDA = 4'h7,
      PCX_FN_SCL = 4'h8,
      PCX_FN_CMPS = 4'h9,
      PCX_FN_CMPA = 4'hA,
      PCX_FN_SYSCK = 4'hB
   } pcx_func_t;

   // Signals that the peripherals hand to the crossbar.
   typedef struct packed {
      logic serial_transmit_out;
      logic sck_o;
      logic sck_oe;
      logic miso_o;
      logic miso_oe;
      logic mosi_o;
      logic mosi_oe;
      logic nss_o;
      logic nss_oe;
      logic sda_o;
      logic scl_o;
      logic async_comparator_out;
      logic sync_comparator_out;
      logic sysclk_o;
   } pcx_periph_out_t;

   // Pin levels that the crossbar hands back to the peripherals.
   typedef struct packed {
      logic serial_receive_in;
      logic sck_i;
      logic miso_i;
      logic mosi_i;
      logic nss_i;
      logic sda_i;
      logic scl_i;
   } pcx_periph_in_t;

endpackage

// ---- dv/pcx_crossbar_properties.sv ----
// Checker for the crossbar's bus and pad ports.
// Assumes it is bound to pcx_crossbar and sees only that module's ports.
module pcx_crossbar_properties
   import pcx_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire pcx_periph_in_t periph_in,
   input wire logic [NUM_PINS-1:0] pad_in,
   input wire logic [NUM_PINS-1:0] pad_out,
   input wire logic [NUM_PINS-1:0] pad_oe,
   input wire logic [NUM_PINS-1:0] pad_pullup,
   input wire logic [NUM_PINS-1:0] pad_rx_en
);
   timeunit 1ns;
   timeprecision 1ns;
   logic acc;
   logic [2:0] off_q;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Marks the access phase of any transfer.
   assign acc = psel & penable;
   // Counts cycles since the crossbar was switched off, saturating at 7.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         off_q <= 3'h7;
      end else if (acc && pwrite && paddr == ADDR_SEL1) begin
         off_q <= pwdata[SEL1_XBAR] ? 3'h0 : 3'h1;
      end else if (off_q != 3'h0 && off_q != 3'h7) begin
         off_q <= off_q + 3'h1;
      end
   end
   chk_ready_access: assert property (acc |-> pready)
      else $error("pready low in access phase");
   chk_err_unmapped: assert property (acc && paddr > ADDR_LAT2 |-> pslverr)
      else $error("no error on unmapped address");
   chk_err_mapped: assert property
      (acc && paddr <= ADDR_LAT2 && paddr[1:0] == 2'b00 |-> !pslverr)
      else $error("error on mapped address");
   chk_analog_quiet: assert property
      ((~pad_rx_en & (pad_oe | pad_pullup)) == '0)
      else $error("analog pin drives or pulls up");
   chk_low_no_pull: assert property
      ((pad_oe & ~pad_out & pad_pullup) == '0)
      else $error("pull-up on while driving low");
   chk_reset_digital: assert property
      ($rose(presetn) |=> pad_rx_en == '1 && pad_oe == '0)
      else $error("pins not digital inputs after reset");
   chk_latch_pin: assert property
      (psel && !penable && !pwrite && paddr == ADDR_LAT0
       |=> (prdata[7:0] & ~$past(pad_in[7:0])) == 8'h00)
      else $error("latch read not the pin level");
   chk_off_no_drive: assert property (off_q >= 3'h3 |-> pad_oe == '0)
      else $error("pin driven with crossbar off");
   chk_off_gpio_in: assert property (off_q >= 3'h3 |-> periph_in == '1)
      else $error("peripheral sees a pin with crossbar off");
   cover property (acc && pslverr);
   cover property (off_q == 3'h1);
   cover property (acc && !pwrite && paddr == ADDR_LAT0);
endmodule

bind pcx_crossbar pcx_crossbar_properties u_chk (.pclk, .presetn, .psel,
   .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
   .periph_in, .pad_in, .pad_out, .pad_oe, .pad_pullup, .pad_rx_en);

// ---- dv/pcx_far_model.sv ----
// Far-side model: the on-chip peripherals and the board at the pins.
// Assumes the bench supplies peripheral levels and the board's pin drive.
module pcx_far_model
   import pcx_pkg::*;
(
   input wire pcx_periph_out_t drive_in,
   input wire logic [NUM_PINS-1:0] ext_level,
   input wire logic [NUM_PINS-1:0] pad_out,
   input wire logic [NUM_PINS-1:0] pad_oe,
   output pcx_periph_out_t periph_out,
   output logic [NUM_PINS-1:0] pad_in
);
   timeunit 1ns;
   timeprecision 1ns;
   // Peripherals present their outputs as plain levels.
   assign periph_out = drive_in;
   // Each pin is a wired-AND of the pad driver and the board's driver.
   assign pad_in = (~pad_oe | pad_out) & ext_level;
endmodule

// ---- dv/priority_crossbar_pin_router_tb_top.sv ----
// Self-checking bench for the crossbar: APB master, pin model, checks.
// Assumes pcx_crossbar, its checker and pcx_far_model are compiled first.
module priority_crossbar_pin_router_tb_top
   import pcx_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic slave_select_mode, xon, pud;
   logic [7:0] paddr, sel0;
   logic [15:0] skip;
   logic [31:0] pwdata, prdata, rd, r, rs = 32'h0000_d83d;
   pcx_periph_out_t po, periph_out;
   pcx_periph_in_t periph_in, epin;
   logic [NUM_PINS-1:0] pad_in, pad_out, pad_oe, pad_pullup, pad_rx_en;
   logic [NUM_PINS-1:0] ext, ink, drv, lat, eoe, eout, epu, lvl;
   int failures, compares, fpin[12];
   pcx_crossbar u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .slave_select_mode, .periph_out,
      .periph_in, .pad_in, .pad_out, .pad_oe, .pad_pullup, .pad_rx_en);
   pcx_far_model u_far (.drive_in(po), .ext_level(ext), .pad_out, .pad_oe,
      .periph_out, .pad_in);
   // Free-running system clock.
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // Xorshift source of stimulus values.
   function logic [31:0] rnd;
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction
   // Compares a seen value with an expected one.
   task cmp(input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         failures++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   // Prints the verdict and ends the run.
   task print_verdict;
      if (failures == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // One APB transfer; waits for pready under a bound.
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         failures++;
         print_verdict();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // Reads a register and checks data and error response.
   task rchk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      cmp(rd, e);
      cmp(err, a > ADDR_LAT2);
   endtask
   // Level at the pin of a function code, or idle high when it owns no pin.
   function logic lv(int f);
      return (fpin[f] < NUM_PINS) ? lvl[fpin[f]] & ink[fpin[f]] : 1'b1;
   endfunction
   // Reference pin map and pad controls built from the settings.
   task automatic model;
      int fn[16];
      int q[$];
      int f;
      logic [15:0] tk;
      logic v, w, od;
      tk = skip;
      foreach (fn[p]) fn[p] = 0;
      foreach (fpin[k]) fpin[k] = 99;
      if (xon) begin
         if (sel0[SEL0_UART]) begin
            fn[4] = 1;
            fn[5] = 2;
            tk[5:4] = 2'b11;
         end
         if (sel0[SEL0_CMPA]) fn[12] = 10;
         if (sel0[SEL0_CMPS]) fn[13] = 9;
         tk[12] = tk[12] | sel0[SEL0_CMPA];
         tk[13] = tk[13] | sel0[SEL0_CMPS];
         if (sel0[SEL0_SPI]) q = '{3, 4, 5};
         if (sel0[SEL0_SPI] && slave_select_mode) q.push_back(6);
         if (sel0[SEL0_SMB]) q = {q, 7, 8};
         if (sel0[SEL0_SYSCK]) q.push_back(11);
         // Lowest free pin in rank order.
         foreach (q[k]) for (int p = 0; p < 16; p++) if (!tk[p]) begin
            fn[p] = q[k];
            tk[p] = 1'b1;
            break;
         end
      end
      for (int p = 0; p < NUM_PINS; p++) begin
         f = (p < 16) ? fn[p] : 0;
         if (f != 0) fpin[f] = p;
         od = !drv[p] || f == 7 || f == 8;
         w = 1'b1;
         case (f)
            0: begin w = xon; v = lat[p]; end
            1: v = po.serial_transmit_out;
            2: begin w = 1'b0; v = 1'b1; end
            3: begin w = po.sck_oe; v = po.sck_o; end
            4: begin w = po.miso_oe; v = po.miso_o; end
            5: begin w = po.mosi_oe; v = po.mosi_o; end
            6: begin w = po.nss_oe; v = po.nss_o; end
            7: v = po.sda_o;
            8: v = po.scl_o;
            9: v = po.sync_comparator_out;
            10: v = po.async_comparator_out;
            default: v = po.sysclk_o;
         endcase
         w = w & ink[p];
         eoe[p] = w & (!od | !v);
         eout[p] = !od & v;
         epu[p] = ink[p] & od & !pud & !eoe[p];
         lvl[p] = (!eoe[p] | eout[p]) & ext[p];
      end
      epin = {lv(2), lv(3), lv(4), lv(5), lv(6), lv(7), lv(8)};
   endtask
   // Lets the map settle, then checks pads, peripheral inputs and latches.
   task settle_chk;
      repeat (4) @(posedge pclk);
      model();
      @(negedge pclk);
      cmp(pad_oe, eoe);
      cmp(pad_out & pad_oe, eout & eoe);
      cmp(pad_pullup, epu);
      cmp(pad_rx_en, ink);
      cmp(periph_in, epin);
      @(posedge pclk);
      rchk(ADDR_LAT0, lvl[7:0] & ink[7:0]);
      rchk(ADDR_LAT1, lvl[15:8] & ink[15:8]);
      rchk(ADDR_LAT2, lvl[16] & ink[16]);
   endtask
   // Writes all settings in the documented order, crossbar last.
   task setup;
      static int ord[13] = '{4, 5, 6, 7, 8, 9, 2, 3, 10, 11, 12, 0, 1};
      logic [7:0] v[13];
      v = '{sel0, {pud, xon, 6'h3F}, skip[7:0], skip[15:8], ink[7:0],
         ink[15:8], {7'h0, ink[16]}, drv[7:0], drv[15:8], {7'h0, drv[16]},
         lat[7:0], lat[15:8], {7'h0, lat[16]}};
      foreach (ord[k]) apb(1'b1, 8'(ord[k] * 4), {24'h0, v[ord[k]]});
      rchk(ADDR_SEL0, {24'h0, sel0 & SEL0_WMASK});
      rchk(ADDR_SEL1, {24'h0, pud, xon, 6'h0});
   endtask
   // Bounds the whole run.
   initial begin
      repeat (100000) @(posedge pclk);
      failures++;
      print_verdict();
   end
   // Main sequence: reset values, crossbar off, then random settings.
   initial begin
      static logic [7:0] rv[10] = '{0, 0, 0, 0, 8'hFF, 8'hFF, 8'h01, 0, 0, 0};
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {slave_select_mode, po, presetn, failures, compares} = '0;
      ext = '1;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      {sel0, xon, pud, skip, drv} = '0;
      {ink, lat} = '1;
      settle_chk();
      foreach (rv[k]) rchk(8'(k * 4), {24'h0, rv[k]});
      rchk(8'h34, 32'h0000_0000);
      apb(1'b1, 8'hFC, 32'hFFFF_FFFF);
      cmp(err, 1'b1);
      sel0 = 8'hFF;
      drv = '1;
      lat = '0;
      slave_select_mode <= 1'b1;
      setup();
      settle_chk();
      for (int i = 0; i < 60; i++) begin
         r = rnd();
         sel0 = r[7:0];
         xon = (i % 5 != 0);
         pud = r[8];
         slave_select_mode <= r[9];
         po <= r[31:18];
         skip = (i % 7 == 0) ? 16'hFFFF : 16'(rnd() & rnd());
         ink = (i % 3 == 0) ? 17'(rnd() | rnd()) : '1;
         drv = 17'(rnd());
         lat = 17'(rnd());
         ext <= 17'(rnd() | rnd());
         setup();
         settle_chk();
      end
      print_verdict();
   end
endmodule
